//--- rtl/sahc_pkg.sv
// Shared constants and types of the converter control block
package sahc_pkg;

    // ------------------------------------------------------------
    // Result format
    // ------------------------------------------------------------
    localparam int RESULT_W  = 13;
    localparam int SIGN_BIT  = 12;
    localparam int MAG_MSB   = 11;
    localparam int TRIALS    = 13;
    localparam int IDX_W     = 4;
    localparam logic [IDX_W-1:0] SIGN_IDX = 4'hc;

    // ------------------------------------------------------------
    // Timing, in converter clock periods
    // ------------------------------------------------------------
    localparam int CAL_PERIODS    = 1396;
    localparam int ZERO_PERIODS   = 26;
    localparam int SAMPLE_PERIODS = 7;
    localparam int CONV_PERIODS   = 27;
    localparam int TAIL_PERIODS   = CONV_PERIODS - SAMPLE_PERIODS - TRIALS;
    localparam int CNT_W          = 11;

    // Correction memory: entry 0 is comparator offset, 1..12 ladder bits
    localparam int CORR_ENTRIES = 13;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SAHC_IDLE,
        SAHC_CAL,
        SAHC_ZERO,
        SAHC_SAMPLE,
        SAHC_TRIAL,
        SAHC_TAIL
    } sahc_state_t;

endpackage

//--- rtl/sahc_sar_if.sv
// Carrier between the sequencer and the approximation register
`timescale 1ns/1ps
`default_nettype none
interface sahc_sar_if;
    logic                             clear;
    logic                             step;
    logic                             comp;
    logic [sahc_pkg::RESULT_W-1:0]    dac_code;
    logic [sahc_pkg::IDX_W-1:0]       trial_idx;
    logic [sahc_pkg::RESULT_W-1:0]    result;

    modport ctrl   (output clear, output step, output comp,
                    input dac_code, input trial_idx, input result);
    modport engine (input clear, input step, input comp,
                    output dac_code, output trial_idx, output result);
endinterface
`default_nettype wire

//--- rtl/sahc_sar.sv
// Successive-approximation register: one result bit per trial
`timescale 1ns/1ps
`default_nettype none
module sahc_sar (
    input  wire logic         core_clk,
    input  wire logic         reset,
    input  wire logic         core_ce,
    sahc_sar_if.engine        sar
);
    logic [sahc_pkg::IDX_W-1:0]     idx;
    logic                           sign;
    logic [sahc_pkg::MAG_MSB:0]     approximation_register;
    logic [sahc_pkg::MAG_MSB:0]     trial_mask;
    logic [sahc_pkg::MAG_MSB:0]     twos;

    // ------------------------------------------------------------
    // Trial sequence
    // ------------------------------------------------------------
    // one bit per trial
    always_ff @(posedge core_clk) begin
        if (reset || (core_ce && sar.clear)) begin
            idx                    <= sahc_pkg::SIGN_IDX;
            sign                   <= 1'b0;
            approximation_register <= '0;
        end else if (core_ce && sar.step) begin
            if (idx == sahc_pkg::SIGN_IDX) begin
                // Sign trial compares against ground: low means negative
                sign <= ~sar.comp;
            end else if (sar.comp) begin
                approximation_register <= approximation_register | trial_mask;
            end
            if (idx != '0) begin
                idx <= idx - 4'h1;
            end
        end
    end

    always_comb begin
        trial_mask = '0;
        if (idx != sahc_pkg::SIGN_IDX) begin
            trial_mask[idx] = 1'b1;
        end
    end

    assign sar.trial_idx = idx;
    assign sar.dac_code  = {1'b0, approximation_register | trial_mask};

    assign twos       = sign ? (~approximation_register + 12'h001) : approximation_register;
    assign sar.result = {sign, twos};
endmodule
`default_nettype wire

//--- rtl/sahc_top.sv
// Converter sequencing and host strobe interface
// ------------------------------------------------------------
// Notes on behaviour
// - Strobes count only while select is low
// - Select and read low drive result
// - Write strobe rising edge starts conversion
// - Calibrate low resets and starts calibration
// - Calibration stores corrections, conversions apply them
// - Zero select low adds auto-zero first
// - Auto-zero adds exactly 26 periods
// - Activity flag low during conversion, calibration
// - Result ready falls once result latched
// - Read, new conversion, calibration clear ready
// - Thirteen-bit two's complement, bit 12 sign
// - Successive approximation, one bit per trial
// - Calibration may be requested any time
// - Calibration keeps flag low 1396 periods
// - Sample 7 periods, then flag falls
// - New start aborts; calibration never aborted
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module sahc_top (
    input  wire logic                          core_clk,
    input  wire logic                          reset,
    input  wire logic                          core_ce,
    input  wire logic                          conv_clk_pin,
    input  wire logic                          select_n,
    input  wire logic                          read_n,
    input  wire logic                          write_n,
    input  wire logic                          calibrate_n,
    input  wire logic                          zero_correct_sel_n,
    input  wire logic                          comp_in,
    output logic [sahc_pkg::RESULT_W-1:0]      result_bus_o,
    output logic                               result_bus_oe,
    output logic                               conv_idle,
    output logic                               result_ready_n,
    output logic [sahc_pkg::RESULT_W-1:0]      dac_code,
    output logic                               dac_trim,
    output logic                               offset_trim,
    output logic                               sample_en,
    output logic                               zero_cycle_en
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int NPIN = 7;
    logic [NPIN-1:0] pin_meta;
    logic [NPIN-1:0] pin_sync;
    logic [NPIN-1:0] pin_prev;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pin_meta <= 7'h3f;
            pin_sync <= 7'h3f;
            pin_prev <= 7'h3f;
        end else if (core_ce) begin
            pin_meta <= {comp_in, zero_correct_sel_n, calibrate_n, write_n,
                         read_n, select_n, conv_clk_pin};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    logic tick;
    logic read_act;
    logic write_start;
    logic cal_req;
    sahc_pkg::sahc_state_t state;
    logic [sahc_pkg::CNT_W-1:0] cnt;

    assign tick = pin_sync[0] & ~pin_prev[0];
    assign read_act = ~pin_sync[1] & ~pin_sync[2];
    assign write_start = ~pin_sync[1] & pin_sync[3] & ~pin_prev[3];
    // calibrate low restarts, but never inside calibration
    assign cal_req = ~pin_sync[4] && (state != sahc_pkg::SAHC_CAL);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    logic last;
    logic finish;
    logic conv_start;

    always_comb begin
        case (state)
            sahc_pkg::SAHC_CAL:    last = (cnt == 11'(sahc_pkg::CAL_PERIODS - 1));
            sahc_pkg::SAHC_ZERO:   last = (cnt == 11'(sahc_pkg::ZERO_PERIODS - 1));
            sahc_pkg::SAHC_SAMPLE: last = (cnt == 11'(sahc_pkg::SAMPLE_PERIODS - 1));
            sahc_pkg::SAHC_TRIAL:  last = (cnt == 11'(sahc_pkg::TRIALS - 1));
            sahc_pkg::SAHC_TAIL:   last = (cnt == 11'(sahc_pkg::TAIL_PERIODS - 1));
            default:               last = 1'b0;
        endcase
    end

    // a write aborts a conversion but not calibration
    assign conv_start = write_start && !cal_req && (state != sahc_pkg::SAHC_CAL);
    assign finish = tick && last && (state == sahc_pkg::SAHC_TAIL) && !cal_req && !conv_start;

    // Power-up enters calibration so corrections are valid before use
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= sahc_pkg::SAHC_CAL;
            cnt   <= '0;
        end else if (core_ce) begin
            if (cal_req) begin
                state <= sahc_pkg::SAHC_CAL;
                cnt   <= '0;
            end else if (conv_start) begin
                // zero select low runs auto-zero first
                state <= pin_sync[5] ? sahc_pkg::SAHC_SAMPLE : sahc_pkg::SAHC_ZERO;
                cnt   <= '0;
            end else if (tick && state != sahc_pkg::SAHC_IDLE) begin
                cnt <= last ? '0 : cnt + 11'h001;
                if (last) begin
                    case (state)
                        sahc_pkg::SAHC_CAL:    state <= sahc_pkg::SAHC_IDLE;
                        sahc_pkg::SAHC_ZERO:   state <= sahc_pkg::SAHC_SAMPLE;
                        sahc_pkg::SAHC_SAMPLE: state <= sahc_pkg::SAHC_TRIAL;
                        sahc_pkg::SAHC_TRIAL:  state <= sahc_pkg::SAHC_TAIL;
                        default:               state <= sahc_pkg::SAHC_IDLE;
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Approximation engine
    // ------------------------------------------------------------
    sahc_sar_if sar_bus ();

    assign sar_bus.clear = conv_start | cal_req;
    assign sar_bus.step  = tick && (state == sahc_pkg::SAHC_TRIAL);
    assign sar_bus.comp  = pin_sync[6];

    sahc_sar u_sar (
        .core_clk (core_clk),
        .reset    (reset),
        .core_ce  (core_ce),
        .sar      (sar_bus)
    );

    // ------------------------------------------------------------
    // Correction memory
    // ------------------------------------------------------------
    logic [sahc_pkg::CORR_ENTRIES-1:0] corr_mem;
    logic                              zero_corr;
    logic                              zero_used;

    // record offset and ladder errors during calibration
    always_ff @(posedge core_clk) begin
        if (reset) begin
            corr_mem <= '0;
        end else if (core_ce && tick && state == sahc_pkg::SAHC_CAL
                     && cnt < 11'(sahc_pkg::CORR_ENTRIES)) begin
            corr_mem[cnt[3:0]] <= pin_sync[6];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            zero_corr <= 1'b0;
            zero_used <= 1'b0;
        end else if (core_ce) begin
            if (conv_start) begin
                zero_used <= ~pin_sync[5];
            end
            if (tick && last && state == sahc_pkg::SAHC_ZERO) begin
                zero_corr <= pin_sync[6];
            end
        end
    end

    // ------------------------------------------------------------
    // Converter-side outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            dac_code      <= '0;
            dac_trim      <= 1'b0;
            offset_trim   <= 1'b0;
            sample_en     <= 1'b0;
            zero_cycle_en <= 1'b0;
            conv_idle     <= 1'b0;
        end else if (core_ce) begin
            dac_code      <= sar_bus.dac_code;
            // stored corrections applied on every trial
            dac_trim      <= corr_mem[sar_bus.trial_idx];
            offset_trim   <= zero_used ? zero_corr : corr_mem[0];
            sample_en     <= (state == sahc_pkg::SAHC_SAMPLE);
            zero_cycle_en <= (state == sahc_pkg::SAHC_ZERO);
            conv_idle     <= !(state == sahc_pkg::SAHC_CAL || state == sahc_pkg::SAHC_TRIAL
                               || state == sahc_pkg::SAHC_TAIL);
        end
    end

    // ------------------------------------------------------------
    // Host side
    // ------------------------------------------------------------
    logic [sahc_pkg::RESULT_W-1:0] result_latch;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            result_latch   <= '0;
            result_bus_o   <= '0;
            result_bus_oe  <= 1'b0;
            result_ready_n <= 1'b1;
        end else if (core_ce) begin
            if (finish) begin
                result_latch <= sar_bus.result;
            end
            result_bus_oe <= read_act;
            result_bus_o  <= result_latch;
            // set wins over read clear; new start or calibration blocks the set, no timeout
            if (finish) begin
                result_ready_n <= 1'b0;
            end else if (read_act || write_start || cal_req) begin
                result_ready_n <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/sahc_front_model.sv
// Converter clock source and ideal comparator facing the control block
`timescale 1ns/1ps
`default_nettype none
module sahc_front_model (
    input  wire logic                          run,
    input  wire logic                          neg,
    input  wire logic [sahc_pkg::MAG_MSB:0]    mag,
    input  wire logic [sahc_pkg::RESULT_W-1:0] dac_code,
    output logic                               conv_clk_pin,
    output logic                               comp_in
);
    // period 252 ns, inside range
    // Rests low while halted so no stray tick reaches the block;
    // edges sit 1 ns off the core grid so sampling never races a clock edge
    initial begin
        conv_clk_pin = 1'b0;
        #1;
        forever #126 conv_clk_pin = run ? ~conv_clk_pin : 1'b0;
    end
    assign comp_in = (dac_code == 13'h0000) ? ~neg : (mag >= dac_code[sahc_pkg::MAG_MSB:0]);
endmodule
`default_nettype wire

//--- dv/sahc_top_monitor.sv
// Concurrent checks on the converter control block ports
`timescale 1ns/1ps
`default_nettype none
module sahc_top_monitor (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic conv_clk_pin,
    input wire logic select_n,
    input wire logic read_n,
    input wire logic calibrate_n,
    input wire logic result_bus_oe,
    input wire logic conv_idle,
    input wire logic result_ready_n,
    input wire logic sample_en,
    input wire logic zero_cycle_en
);
    logic [2:0]  ck;
    logic        tick;
    logic        samp_q;
    logic        zero_q;
    logic [10:0] low_ticks;
    logic [3:0]  samp_ticks;
    logic [4:0]  zero_ticks;

    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    // Ticks counted two flops late too, so phase counts tolerate the sync depth
    assign tick = ck[1] & ~ck[2];
    always_ff @(posedge core_clk) ck <= {ck[1:0], conv_clk_pin};
    always_ff @(posedge core_clk) samp_q <= sample_en;
    always_ff @(posedge core_clk) zero_q <= zero_cycle_en;
    always_ff @(posedge core_clk) begin
        if (reset || conv_idle) low_ticks <= 11'h000;
        else if (tick) low_ticks <= low_ticks + 11'h001;
    end
    always_ff @(posedge core_clk) begin
        if (reset || (sample_en && !samp_q)) samp_ticks <= 4'h0;
        else if (tick && (sample_en || samp_q)) samp_ticks <= samp_ticks + 4'h1;
    end
    always_ff @(posedge core_clk) begin
        if (reset || (zero_cycle_en && !zero_q)) zero_ticks <= 5'h00;
        else if (tick && (zero_cycle_en || zero_q)) zero_ticks <= zero_ticks + 5'h01;
    end

    property p_bus_off;
        (select_n || read_n) [*4] |-> !result_bus_oe;
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("bus driven without read");
    property p_read_drive;
        (!select_n && !read_n) [*5] |-> result_bus_oe;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("bus idle during read");
    property p_read_clear;
        (!select_n && !read_n) [*5] |-> result_ready_n;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("ready kept over read");
    property p_ready_hold;
        (!result_ready_n && select_n && calibrate_n) [*4] |=> !result_ready_n;
    endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("ready dropped alone");
    property p_ready_fall;
        $fell(result_ready_n) |-> ##1 $rose(conv_idle);
    endproperty
    a_ready_fall: assert property (p_ready_fall) else $error("ready without completion");
    property p_flag_span;
        $rose(conv_idle) |-> (low_ticks == 11'(sahc_pkg::CONV_PERIODS - sahc_pkg::SAMPLE_PERIODS)
                              || low_ticks == 11'(sahc_pkg::CAL_PERIODS));
    endproperty
    a_flag_span: assert property (p_flag_span) else $error("activity span wrong");
    property p_cal_keep;
        !conv_idle && low_ticks > 11'h014 && low_ticks < 11'h570 |=> !conv_idle;
    endproperty
    a_cal_keep: assert property (p_cal_keep) else $error("calibration cut short");
    property p_sample_len;
        $fell(conv_idle) |-> samp_ticks == 4'(sahc_pkg::SAMPLE_PERIODS);
    endproperty
    a_sample_len: assert property (p_sample_len) else $error("sampling length wrong");
    property p_zero_len;
        $fell(zero_cycle_en) |-> ##1 zero_ticks == 5'(sahc_pkg::ZERO_PERIODS);
    endproperty
    a_zero_len: assert property (p_zero_len) else $error("auto-zero length wrong");

    c_read: cover property ($rose(result_bus_oe));
    c_done: cover property ($fell(result_ready_n));
    c_zero: cover property ($rose(zero_cycle_en));
endmodule
bind sahc_top sahc_top_monitor sahc_top_monitor_inst (
    .core_clk       (core_clk),
    .reset          (reset),
    .conv_clk_pin   (conv_clk_pin),
    .select_n       (select_n),
    .read_n         (read_n),
    .calibrate_n    (calibrate_n),
    .result_bus_oe  (result_bus_oe),
    .conv_idle      (conv_idle),
    .result_ready_n (result_ready_n),
    .sample_en      (sample_en),
    .zero_cycle_en  (zero_cycle_en)
);
`default_nettype wire

//--- dv/sahc_top_bench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sahc_top_bench;
    localparam int SP = sahc_pkg::SAMPLE_PERIODS;
    localparam int AP = sahc_pkg::CONV_PERIODS - SP;
    localparam int ZP = sahc_pkg::ZERO_PERIODS;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        core_ce = 1'b1;
    logic        select_n = 1'b1;
    logic        read_n = 1'b1;
    logic        write_n = 1'b1;
    logic        calibrate_n = 1'b1;
    logic        zero_correct_sel_n = 1'b1;
    logic        run = 1'b0;
    logic        neg = 1'b0;
    logic [11:0] mag = 12'h000;
    logic [11:0] m5;
    logic [12:0] result_bus_o, dac_code;
    logic        conv_clk_pin, comp_in, result_bus_oe, conv_idle, result_ready_n;
    logic        dac_trim, offset_trim, sample_en, zero_cycle_en;
    logic [31:0] r;
    int          bad_count = 0, checks = 0, seed = 13246, cycles = 0, n;

    always #2 core_clk = ~core_clk;
    sahc_top sahc_top_inst (
        .core_clk           (core_clk),
        .reset              (reset),
        .core_ce            (core_ce),
        .conv_clk_pin       (conv_clk_pin),
        .select_n           (select_n),
        .read_n             (read_n),
        .write_n            (write_n),
        .calibrate_n        (calibrate_n),
        .zero_correct_sel_n (zero_correct_sel_n),
        .comp_in            (comp_in),
        .result_bus_o       (result_bus_o),
        .result_bus_oe      (result_bus_oe),
        .conv_idle          (conv_idle),
        .result_ready_n     (result_ready_n),
        .dac_code           (dac_code),
        .dac_trim           (dac_trim),
        .offset_trim        (offset_trim),
        .sample_en          (sample_en),
        .zero_cycle_en      (zero_cycle_en)
    );
    sahc_front_model sahc_front_model_inst (
        .run          (run),
        .neg          (neg),
        .mag          (mag),
        .dac_code     (dac_code),
        .conv_clk_pin (conv_clk_pin),
        .comp_in      (comp_in)
    );

    task automatic report_and_stop;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Run needs about 95000 cycles, mostly the power-up calibration
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 99000) begin
            bad_count++;
            report_and_stop;
        end
    end
    task automatic check(input logic [12:0] got, input logic [12:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check({12'h000, got}, {12'h000, exp});
    endtask
    function automatic logic [12:0] expect_word(input logic nv, input logic [11:0] m);
        return nv ? 13'h0000 - {1'b0, m} : {1'b0, m};
    endfunction
    task automatic start(input logic az_n, input logic nv, input logic [11:0] m);
        @(posedge conv_clk_pin);
        @(negedge core_clk);
        zero_correct_sel_n = az_n;
        neg = nv;
        mag = m;
        select_n = 1'b0;
        write_n = 1'b0;
        repeat (3) @(negedge core_clk);
        write_n = 1'b1;
        repeat (3) @(negedge core_clk);
        select_n = 1'b1;
    endtask
    task automatic ticks_until(input logic idle_sel, input logic lvl, output int e);
        logic p;
        e = 0;
        p = conv_clk_pin;
        while ((idle_sel ? conv_idle : result_ready_n) !== lvl) begin
            @(negedge core_clk);
            if (conv_clk_pin && !p) e++;
            p = conv_clk_pin;
        end
    endtask
    task automatic read_chk(input logic [12:0] exp);
        @(negedge core_clk);
        select_n = 1'b0;
        read_n = 1'b0;
        repeat (5) @(negedge core_clk);
        check_bit(result_bus_oe, 1'b1);
        check(result_bus_o, exp);
        check_bit(result_ready_n, 1'b1);
        read_n = 1'b1;
        select_n = 1'b1;
        repeat (5) @(negedge core_clk);
        check_bit(result_bus_oe, 1'b0);
    endtask

    initial begin
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        repeat (2) @(negedge core_clk);
        run = 1'b1;
        ticks_until(1'b1, 1'b1, n);
        check(13'(n), 13'(sahc_pkg::CAL_PERIODS));
        start(1'b1, 1'b0, 12'hfff);
        ticks_until(1'b1, 1'b0, n);
        check(13'(n), 13'(SP));
        ticks_until(1'b0, 1'b0, n);
        check(13'(n), 13'(AP));
        // Calibration saw a positive input, so every stored correction reads high
        check_bit(dac_trim, 1'b1);
        check_bit(offset_trim, 1'b1);
        @(negedge core_clk);
        write_n = 1'b0;
        read_n = 1'b0;
        repeat (5) @(negedge core_clk);
        check_bit(result_bus_oe, 1'b0);
        write_n = 1'b1;
        read_n = 1'b1;
        repeat (6) @(negedge core_clk);
        check_bit(result_ready_n, 1'b0);
        read_chk(expect_word(1'b0, 12'hfff));
        r = $random(seed);
        start(1'b1, r[12], r[11:0]);
        ticks_until(1'b0, 1'b0, n);
        check(13'(n), 13'(SP + AP));
        r = $random(seed);
        start(1'b1, r[12], r[11:0]);
        repeat (4) @(negedge core_clk);
        check_bit(result_ready_n, 1'b1);
        repeat (3) @(posedge conv_clk_pin);
        r = $random(seed);
        m5 = r[11:0] | 12'h001;
        start(1'b0, 1'b1, m5);
        ticks_until(1'b1, 1'b0, n);
        check(13'(n), 13'(ZP + SP));
        ticks_until(1'b0, 1'b0, n);
        check(13'(n), 13'(AP));
        // Auto-zero saw a negative input, so its offset value reads low
        check_bit(offset_trim, 1'b0);
        read_chk(expect_word(1'b1, m5));
        @(negedge core_clk);
        calibrate_n = 1'b0;
        repeat (3) @(negedge core_clk);
        calibrate_n = 1'b1;
        repeat (6) @(negedge core_clk);
        check_bit(conv_idle, 1'b0);
        // A start inside calibration must not leave the calibration phase
        start(1'b1, 1'b0, 12'h000);
        repeat (4) @(negedge core_clk);
        check_bit(conv_idle, 1'b0);
        check_bit(sample_en, 1'b0);
        report_and_stop;
    end
endmodule
`default_nettype wire
